// file: rtl/eeprom_autoload_access.sv
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "eeprom_cfg.svh"

// Summary of operation
// - A written 0 to 1 on initiate starts one cycle; command picks read/write.
// - Initiate clears itself when the software cycle has finished.
// - Error flag reads 1 after a missing acknowledge, else 0.
// - Autoload-complete flag sets only after a successful autoload.
// - Serial clock is core clock over 4096, 2048, 1024 or 128.
// - Autoload runs after every reset; the control bit is still 0 from reset when that is decided.
// - Fast bit makes autoload run 32 times faster.
// - Autoload status reads 1 only while autoload is in progress.
// - The 7-bit word address field selects the word for software cycles.
// - A software write sends the 16-bit data field.
module eeprom_autoload_access
#(
  parameter int AL_WORDS = 4
)
(
  // Clock and reset.
  input  wire logic                  CLOCK,
  input  wire logic                  RSTN,
  // AHB-Lite slave.
  input  wire logic                  HSEL,
  input  wire logic [31:0]           HADDR,
  input  wire logic [1:0]            HTRANS,
  input  wire logic                  HWRITE,
  input  wire logic [2:0]            HSIZE,
  input  wire logic [31:0]           HWDATA,
  input  wire logic                  HREADY,
  output logic      [31:0]           HRDATA,
  output logic                       HREADYOUT,
  output logic                       HRESP,
  // Interrupt.
  output logic                       IRQ,
  // Serial EEPROM link.
  output logic                       EE_SCL,
  input  wire logic                  EE_SDA_IN,
  output logic                       EE_SDA_OUT,
  output logic                       EE_SDA_OEN,
  // Words fetched by autoload.
  output eeprom_pkg::cfg_load_t      CFG_LOAD
);

  logic                   init_ff, cmd_ff, err_ff, aldone_ff, aldis_ff;
  logic                   fast_ff, albusy_ff, alstart_ff;
  logic                   nxt_init, nxt_cmd, nxt_err, nxt_aldone, nxt_aldis;
  logic                   nxt_fast, nxt_albusy, nxt_alstart;
  logic [1:0]             div_ff, nxt_div;
  logic [6:0]             waddr_ff, nxt_waddr, alword_ff, nxt_alword;
  logic [15:0]            data_ff, nxt_data;
  logic [2:0]             irq_st_ff, nxt_irq_st, irq_mask_ff, nxt_irq_mask;
  eeprom_pkg::bus_aph_t   aph_ff, nxt_aph;
  logic                   rwait_ff, nxt_rwait;
  logic [31:0]            hrdata_ff, nxt_hrdata, ctrl_word;
  eeprom_pkg::cfg_load_t  load_ff, nxt_load;
  logic                   sda_s1_ff, sda_s2_ff;

  eeprom_pkg::eng_state_t state_ff, nxt_state;
  logic [1:0]             q_ff, nxt_q;
  logic [2:0]             step_ff, nxt_step;
  logic [3:0]             bcnt_ff, nxt_bcnt;
  logic [7:0]             sh_ff, nxt_sh;
  logic [15:0]            rx_ff, nxt_rx, ewd_ff, nxt_ewd;
  logic [6:0]             eaddr_ff, nxt_eaddr;
  logic                   scl_ff, nxt_scl, drv_ff, nxt_drv;
  logic                   rd_ff, nxt_rd, nack_ff, nxt_nack;
  logic                   jobsw_ff, nxt_jobsw;
  logic                   tick, start_sw, start_al, eng_done, ack_miss;
  eeprom_pkg::step_kind_t cur_kind, new_kind;

  function automatic eeprom_pkg::step_kind_t step_kind(input logic rd,
                                                       input logic [2:0] s);
    if (rd)
    begin
      case (s)
        3'h0, 3'h3: step_kind = eeprom_pkg::K_START;
        3'h5, 3'h6: step_kind = eeprom_pkg::K_RX;
        3'h7:       step_kind = eeprom_pkg::K_STOP;
        default:    step_kind = eeprom_pkg::K_TX;
      endcase
    end
    else
    begin
      case (s)
        3'h0:    step_kind = eeprom_pkg::K_START;
        3'h5:    step_kind = eeprom_pkg::K_STOP;
        default: step_kind = eeprom_pkg::K_TX;
      endcase
    end
  endfunction

  // Autoload uses the fast rate only while it runs.
  eeprom_tick_gen #(.CW(11)) u_tick (
    .clock (CLOCK),
    .rstn  (RSTN),
    .sel   (div_ff),
    .fast  (fast_ff && albusy_ff),
    .tick  (tick)
  );

  assign start_sw = init_ff && state_ff == eeprom_pkg::ST_IDLE
                    && !albusy_ff && !alstart_ff;
  assign start_al = albusy_ff && state_ff == eeprom_pkg::ST_IDLE;
  assign cur_kind = step_kind(rd_ff, step_ff);
  assign new_kind = step_kind(rd_ff, step_ff + 3'h1);

  // Serial engine: start, byte slots with acknowledge, stop.
  always_comb
  begin
    nxt_state = state_ff;
    nxt_q     = q_ff;
    nxt_step  = step_ff;
    nxt_bcnt  = bcnt_ff;
    nxt_sh    = sh_ff;
    nxt_rx    = rx_ff;
    nxt_ewd   = ewd_ff;
    nxt_eaddr = eaddr_ff;
    nxt_scl   = scl_ff;
    nxt_drv   = drv_ff;
    nxt_rd    = rd_ff;
    nxt_nack  = nack_ff;
    nxt_jobsw = jobsw_ff;
    eng_done  = 1'b0;
    ack_miss  = 1'b0;
    if (start_sw || start_al)
    begin
      nxt_state = eeprom_pkg::ST_START;
      nxt_q     = 2'h0;
      nxt_step  = 3'h0;
      nxt_nack  = 1'b0;
      nxt_jobsw = start_sw;
      nxt_rd    = start_sw ? !cmd_ff : 1'b1;
      nxt_eaddr = start_sw ? waddr_ff : alword_ff;
      nxt_ewd   = data_ff;
    end
    else if (tick && state_ff != eeprom_pkg::ST_IDLE)
    begin
      nxt_q = q_ff + 2'h1;
      case (state_ff)
        eeprom_pkg::ST_START:
        begin
          if (q_ff == 2'h0)
          begin
            nxt_scl = 1'b1;
            nxt_drv = 1'b0;
          end
          if (q_ff == 2'h2)
            nxt_drv = 1'b1;
          if (q_ff == 2'h3)
            nxt_scl = 1'b0;
        end
        eeprom_pkg::ST_BIT:
        begin
          if (q_ff == 2'h0)
          begin
            if (cur_kind == eeprom_pkg::K_TX)
              nxt_drv = (bcnt_ff < 4'h8) ? !sh_ff[7] : 1'b0;
            else
              nxt_drv = (bcnt_ff == 4'h8) && (step_ff == 3'h5);
          end
          if (q_ff == 2'h1)
            nxt_scl = 1'b1;
          if (q_ff == 2'h2)
          begin
            if (cur_kind == eeprom_pkg::K_TX && bcnt_ff == 4'h8 && sda_s2_ff)
            begin
              nxt_nack = 1'b1;
              ack_miss = 1'b1;
            end
            if (cur_kind == eeprom_pkg::K_RX && bcnt_ff < 4'h8)
              nxt_rx = {rx_ff[14:0], sda_s2_ff};
          end
          if (q_ff == 2'h3)
          begin
            nxt_scl  = 1'b0;
            nxt_sh   = {sh_ff[6:0], 1'b0};
            nxt_bcnt = bcnt_ff + 4'h1;
          end
        end
        eeprom_pkg::ST_STOP:
        begin
          if (q_ff == 2'h0)
            nxt_drv = 1'b1;
          if (q_ff == 2'h1)
            nxt_scl = 1'b1;
          if (q_ff == 2'h2)
            nxt_drv = 1'b0;
          if (q_ff == 2'h3)
          begin
            nxt_state = eeprom_pkg::ST_IDLE;
            eng_done  = 1'b1;
          end
        end
        default: nxt_state = eeprom_pkg::ST_IDLE;
      endcase
      // Move to the next step at the end of a start or a byte slot.
      if (q_ff == 2'h3 && (state_ff == eeprom_pkg::ST_START
          || (state_ff == eeprom_pkg::ST_BIT && bcnt_ff == 4'h8)))
      begin
        nxt_step = step_ff + 3'h1;
        nxt_bcnt = 4'h0;
        case (step_ff + 3'h1)
          3'h1:    nxt_sh = {`EE_DEV_SEL, 1'b0};
          3'h2:    nxt_sh = {eaddr_ff, 1'b0};
          3'h3:    nxt_sh = ewd_ff[15:8];
          3'h4:    nxt_sh = rd_ff ? {`EE_DEV_SEL, 1'b1} : ewd_ff[7:0];
          default: nxt_sh = 8'h00;
        endcase
        if (nxt_nack || new_kind == eeprom_pkg::K_STOP)
          nxt_state = eeprom_pkg::ST_STOP;
        else if (new_kind == eeprom_pkg::K_START)
          nxt_state = eeprom_pkg::ST_START;
        else
          nxt_state = eeprom_pkg::ST_BIT;
      end
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      state_ff <= eeprom_pkg::ST_IDLE;
      q_ff     <= 2'h0;
      step_ff  <= 3'h0;
      bcnt_ff  <= 4'h0;
      sh_ff    <= 8'h00;
      rx_ff    <= 16'h0000;
      ewd_ff   <= 16'h0000;
      eaddr_ff <= 7'h00;
      scl_ff   <= 1'b1;
      drv_ff   <= 1'b0;
      rd_ff    <= 1'b0;
      nack_ff  <= 1'b0;
      jobsw_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      q_ff     <= nxt_q;
      step_ff  <= nxt_step;
      bcnt_ff  <= nxt_bcnt;
      sh_ff    <= nxt_sh;
      rx_ff    <= nxt_rx;
      ewd_ff   <= nxt_ewd;
      eaddr_ff <= nxt_eaddr;
      scl_ff   <= nxt_scl;
      drv_ff   <= nxt_drv;
      rd_ff    <= nxt_rd;
      nack_ff  <= nxt_nack;
      jobsw_ff <= nxt_jobsw;
    end
  end

  always_comb
  begin
    ctrl_word = `EE_CTRL_RESET;
    ctrl_word[`EE_INIT_BIT]                   = init_ff;
    ctrl_word[`EE_CMD_BIT]                    = cmd_ff;
    ctrl_word[`EE_ERR_BIT]                    = err_ff;
    ctrl_word[`EE_ALDONE_BIT]                 = aldone_ff;
    ctrl_word[`EE_DIV_MSB:`EE_DIV_LSB]        = div_ff;
    ctrl_word[`EE_ALDIS_BIT]                  = aldis_ff;
    ctrl_word[`EE_FAST_BIT]                   = fast_ff;
    ctrl_word[`EE_ALBUSY_BIT]                 = albusy_ff;
    ctrl_word[`EE_WADDR_MSB:`EE_WADDR_LSB]    = waddr_ff;
    ctrl_word[`EE_DATA_MSB:`EE_DATA_LSB]      = data_ff;
  end

  // Bus slave, register file, autoload sequencing and interrupts.
  always_comb
  begin
    nxt_init     = init_ff;
    nxt_cmd      = cmd_ff;
    nxt_err      = err_ff;
    nxt_aldone   = aldone_ff;
    nxt_div      = div_ff;
    nxt_aldis    = aldis_ff;
    nxt_fast     = fast_ff;
    nxt_waddr    = waddr_ff;
    nxt_data     = data_ff;
    nxt_albusy   = albusy_ff;
    nxt_alstart  = 1'b0;
    nxt_alword   = alword_ff;
    nxt_irq_st   = irq_st_ff;
    nxt_irq_mask = irq_mask_ff;
    nxt_aph      = aph_ff;
    nxt_rwait    = 1'b0;
    nxt_hrdata   = hrdata_ff;
    nxt_load     = '0;
    if (HREADY)
    begin
      nxt_aph.valid = HSEL && HTRANS[1];
      nxt_aph.write = HWRITE;
      nxt_aph.addr  = HADDR[7:0];
    end
    if (aph_ff.valid && !aph_ff.write && !rwait_ff)
    begin
      nxt_rwait = 1'b1;
      case (aph_ff.addr)
        `EE_CTRL_OFFSET:     nxt_hrdata = ctrl_word;
        `EE_IRQ_STAT_OFFSET: nxt_hrdata = {29'h0, irq_st_ff};
        `EE_IRQ_MASK_OFFSET: nxt_hrdata = {29'h0, irq_mask_ff};
        default:             nxt_hrdata = 32'h0000_0000;
      endcase
    end
    if (aph_ff.valid && aph_ff.write)
    begin
      case (aph_ff.addr)
        `EE_CTRL_OFFSET:
        begin
          if (!init_ff && HWDATA[`EE_INIT_BIT])
            nxt_init = 1'b1;
          nxt_cmd   = HWDATA[`EE_CMD_BIT];
          nxt_div   = HWDATA[`EE_DIV_MSB:`EE_DIV_LSB];
          nxt_aldis = HWDATA[`EE_ALDIS_BIT];
          nxt_fast  = HWDATA[`EE_FAST_BIT];
          nxt_waddr = HWDATA[`EE_WADDR_MSB:`EE_WADDR_LSB];
          nxt_data  = HWDATA[`EE_DATA_MSB:`EE_DATA_LSB];
        end
        `EE_IRQ_STAT_OFFSET: nxt_irq_st   = irq_st_ff & ~HWDATA[2:0];
        `EE_IRQ_MASK_OFFSET: nxt_irq_mask = HWDATA[2:0];
        default:             nxt_irq_mask = irq_mask_ff;
      endcase
    end
    // One autoload attempt follows every reset; the disable bit is still 0 from reset then.
    if (alstart_ff && !aldis_ff)
    begin
      nxt_albusy = 1'b1;
      nxt_alword = 7'h00;
    end
    if (start_sw || start_al)
      nxt_err = 1'b0;
    if (ack_miss)
    begin
      nxt_err = 1'b1;
      nxt_irq_st[`EE_IRQ_ERR] = 1'b1;
    end
    if (eng_done && jobsw_ff)
    begin
      nxt_init = 1'b0;
      nxt_irq_st[`EE_IRQ_SW_DONE] = 1'b1;
      if (rd_ff && !nack_ff)
        nxt_data = rx_ff;
    end
    if (eng_done && !jobsw_ff)
    begin
      if (nack_ff)
        nxt_albusy = 1'b0;
      else
      begin
        nxt_load.valid = 1'b1;
        nxt_load.addr  = alword_ff;
        nxt_load.data  = rx_ff;
        nxt_alword     = alword_ff + 7'h01;
        if (alword_ff == 7'(AL_WORDS - 1))
        begin
          nxt_albusy = 1'b0;
          nxt_aldone = 1'b1;
          nxt_irq_st[`EE_IRQ_AL_DONE] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      init_ff     <= 1'b0;
      cmd_ff      <= 1'b0;
      err_ff      <= 1'b0;
      aldone_ff   <= 1'b0;
      div_ff      <= 2'h0;
      aldis_ff    <= 1'b0;
      fast_ff     <= 1'b0;
      waddr_ff    <= 7'h00;
      data_ff     <= 16'h0000;
      albusy_ff   <= 1'b0;
      alstart_ff  <= 1'b1;
      alword_ff   <= 7'h00;
      irq_st_ff   <= `EE_IRQ_RESET;
      irq_mask_ff <= `EE_IRQ_RESET;
      aph_ff      <= '0;
      rwait_ff    <= 1'b0;
      hrdata_ff   <= 32'h0000_0000;
      load_ff     <= '0;
      sda_s1_ff   <= 1'b1;
      sda_s2_ff   <= 1'b1;
    end
    else
    begin
      init_ff     <= nxt_init;
      cmd_ff      <= nxt_cmd;
      err_ff      <= nxt_err;
      aldone_ff   <= nxt_aldone;
      div_ff      <= nxt_div;
      aldis_ff    <= nxt_aldis;
      fast_ff     <= nxt_fast;
      waddr_ff    <= nxt_waddr;
      data_ff     <= nxt_data;
      albusy_ff   <= nxt_albusy;
      alstart_ff  <= nxt_alstart;
      alword_ff   <= nxt_alword;
      irq_st_ff   <= nxt_irq_st;
      irq_mask_ff <= nxt_irq_mask;
      aph_ff      <= nxt_aph;
      rwait_ff    <= nxt_rwait;
      hrdata_ff   <= nxt_hrdata;
      load_ff     <= nxt_load;
      sda_s1_ff   <= EE_SDA_IN;
      sda_s2_ff   <= sda_s1_ff;
    end
  end

  assign HREADYOUT  = !(aph_ff.valid && !aph_ff.write && !rwait_ff);
  assign HRESP      = 1'b0;
  assign HRDATA     = hrdata_ff;
  assign IRQ        = |(irq_st_ff & irq_mask_ff);
  assign EE_SCL     = scl_ff;
  assign EE_SDA_OUT = 1'b0;
  assign EE_SDA_OEN = !drv_ff;
  assign CFG_LOAD   = load_ff;

  AST_START_SW: assert property (@(posedge CLOCK) disable iff (!RSTN)
    $rose(init_ff) && state_ff == eeprom_pkg::ST_IDLE && !albusy_ff
      && !alstart_ff |=> state_ff == eeprom_pkg::ST_START && rd_ff == !cmd_ff)
    else $error("Initiate did not start a cycle of the chosen direction.");

  AST_INIT_CLEAR: assert property (@(posedge CLOCK) disable iff (!RSTN)
    eng_done && jobsw_ff |=> !init_ff ##1 state_ff == eeprom_pkg::ST_IDLE)
    else $error("Initiate bit did not clear after the cycle ended.");

  AST_ERR_SET: assert property (@(posedge CLOCK) disable iff (!RSTN)
    ack_miss |=> err_ff [*2])
    else $error("Missing acknowledge did not set the error flag.");

  AST_ERR_CLEAR: assert property (@(posedge CLOCK) disable iff (!RSTN)
    start_sw |=> !err_ff)
    else $error("Error flag not cleared at the start of a cycle.");

  AST_AL_DONE: assert property (@(posedge CLOCK) disable iff (!RSTN)
    $rose(aldone_ff) |-> $past(albusy_ff) && !$past(nack_ff) && !albusy_ff)
    else $error("Autoload complete set without a clean autoload.");

  AST_AL_SKIP: assert property (@(posedge CLOCK) disable iff (!RSTN)
    alstart_ff && aldis_ff |=> !albusy_ff [*2])
    else $error("Autoload ran while disabled.");

  AST_AL_RUN: assert property (@(posedge CLOCK) disable iff (!RSTN)
    alstart_ff && !aldis_ff |=> albusy_ff)
    else $error("Enabled autoload did not start after reset.");

  AST_AL_BUSY: assert property (@(posedge CLOCK) disable iff (!RSTN)
    $rose(albusy_ff) |-> $past(alstart_ff) && ctrl_word[`EE_ALBUSY_BIT])
    else $error("Autoload status rose without an autoload start.");

  AST_ADDR: assert property (@(posedge CLOCK) disable iff (!RSTN)
    start_sw |=> eaddr_ff == $past(waddr_ff) && ewd_ff == $past(data_ff))
    else $error("Software cycle did not latch address and data.");

  AST_RD_DATA: assert property (@(posedge CLOCK) disable iff (!RSTN)
    eng_done && jobsw_ff && rd_ff && !nack_ff |=> data_ff == $past(rx_ff))
    else $error("Read word was not stored in the data field.");

endmodule

// file: rtl/eeprom_tick_gen.sv
`timescale 1ns/1ps
`include "eeprom_cfg.svh"

module eeprom_tick_gen
#(
  parameter int CW = 11
)
(
  // Clock and reset.
  input  wire logic       clock,
  input  wire logic       rstn,
  // Rate selection.
  input  wire logic [1:0] sel,
  input  wire logic       fast,
  // Quarter bit period strobe.
  output logic            tick
);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic [CW-1:0] lim;

  // One tick every quarter of a serial clock period.
  always_comb
  begin
    case (sel)
      2'h0:    lim = CW'(`EE_SCL_DIV00 / 4);
      2'h1:    lim = CW'(`EE_SCL_DIV01 / 4);
      2'h2:    lim = CW'(`EE_SCL_DIV10 / 4);
      default: lim = CW'(`EE_SCL_DIV11 / 4);
    endcase
    if (fast)
    begin
      lim = lim >> `EE_FAST_SHIFT;
    end
    nxt_cnt = (cnt_ff == '0) ? lim - CW'(1) : cnt_ff - CW'(1);
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
      cnt_ff <= '0;
    else
      cnt_ff <= nxt_cnt;
  end

  assign tick = (cnt_ff == '0);

  AST_QUARTER_128: assert property (@(posedge clock) disable iff (!rstn)
    tick && sel == 2'h3 && !fast && $past(sel, 32) == 2'h3
      && !$past(fast, 32) && $past(tick, 32) |-> ##32 tick)
    else $error("Quarter period for divide by 128 is not 32 cycles.");

  AST_FAST_RATE: assert property (@(posedge clock) disable iff (!rstn)
    tick && sel == 2'h3 && fast && $past(sel) == 2'h3 && $past(fast)
      |-> ##1 tick)
    else $error("Fast rate does not tick every cycle at divide by 128.");

endmodule

// file: shared/eeprom_cfg.svh
`ifndef EEPROM_CFG_SVH
`define EEPROM_CFG_SVH

// Register byte offsets.
`define EE_CTRL_OFFSET     8'h70
`define EE_IRQ_STAT_OFFSET 8'h74
`define EE_IRQ_MASK_OFFSET 8'h78

// Control/status field positions.
`define EE_INIT_BIT   0
`define EE_CMD_BIT    1
`define EE_ERR_BIT    2
`define EE_ALDONE_BIT 3
`define EE_DIV_LSB    4
`define EE_DIV_MSB    5
`define EE_ALDIS_BIT  6
`define EE_FAST_BIT   7
`define EE_ALBUSY_BIT 8
`define EE_WADDR_LSB  9
`define EE_WADDR_MSB  15
`define EE_DATA_LSB   16
`define EE_DATA_MSB   31

// Reset values.
`define EE_CTRL_RESET 32'h0000_0000
`define EE_IRQ_RESET  3'h0

// Interrupt status and mask bit positions.
`define EE_IRQ_SW_DONE 0
`define EE_IRQ_ERR     1
`define EE_IRQ_AL_DONE 2

// Serial clock divisors of the core clock and the fast autoload factor.
`define EE_SCL_DIV00 4096
`define EE_SCL_DIV01 2048
`define EE_SCL_DIV10 1024
`define EE_SCL_DIV11 128
`define EE_FAST_SHIFT 5

// Seven-bit device select code on the serial link.
`define EE_DEV_SEL 7'h50

`endif

// file: shared/eeprom_pkg.sv
package eeprom_pkg;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_BIT   = 2'b10,
    ST_STOP  = 2'b11
  } eng_state_t;

  typedef enum logic [1:0] {
    K_START = 2'b00,
    K_TX    = 2'b01,
    K_RX    = 2'b10,
    K_STOP  = 2'b11
  } step_kind_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } bus_aph_t;

  typedef struct packed {
    logic        valid;
    logic [6:0]  addr;
    logic [15:0] data;
  } cfg_load_t;

endpackage

// file: testbench/eeprom_autoload_access_tb.sv
`timescale 1ns/1ps
`include "eeprom_cfg.svh"

module eeprom_autoload_access_tb;
  logic                  CLOCK;
  logic                  RSTN;
  logic                  HSEL;
  logic [31:0]           HADDR;
  logic [1:0]            HTRANS;
  logic                  HWRITE;
  logic [2:0]            HSIZE;
  logic [31:0]           HWDATA;
  logic [31:0]           HRDATA;
  logic                  HREADYOUT;
  logic                  HRESP;
  logic                  IRQ;
  logic                  EE_SCL;
  logic                  EE_SDA_OUT;
  logic                  EE_SDA_OEN;
  eeprom_pkg::cfg_load_t CFG_LOAD;
  logic                  nack;
  logic                  pull_low;
  logic [31:0]           rd;
  logic [22:0]           load_q [$];
  int                    bad_count;
  int                    num_checks;
  wire                   sda = (EE_SDA_OEN | EE_SDA_OUT) & ~pull_low;

  eeprom_autoload_access #(.AL_WORDS(2)) eeprom_autoload_access_inst
  (
    .CLOCK(CLOCK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .IRQ(IRQ), .EE_SCL(EE_SCL), .EE_SDA_IN(sda),
    .EE_SDA_OUT(EE_SDA_OUT), .EE_SDA_OEN(EE_SDA_OEN), .CFG_LOAD(CFG_LOAD)
  );

  eeprom_model eeprom_model_inst
  (
    .scl(EE_SCL), .sda(sda), .nack(nack), .pull_low(pull_low)
  );

  initial
  begin
    CLOCK = 1'b0;
    forever #20 CLOCK = ~CLOCK;
  end

  always @(posedge CLOCK)
    if (CFG_LOAD.valid === 1'b1)
      load_q.push_back({CFG_LOAD.addr, CFG_LOAD.data});

  function automatic logic [15:0] mword(input int w);
    return {8'(2 * w) ^ 8'h5A, 8'(2 * w + 1) ^ 8'h5A};
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic hang(input logic t);
    if (t)
    begin
      bad_count++;
      $display("MISMATCH wait exp done got timeout");
      close_out();
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge CLOCK);
      n++;
    end
    while (HREADYOUT !== 1'b1 && n < 50);
    hang(n == 50);
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    HSEL   <= 1'b1;
    HTRANS <= 2'h2;
    HADDR  <= {24'h0, a};
    HWRITE <= w;
    wait_ready();
    HSEL   <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    wait_ready();
    rd = HRDATA;
  endtask

  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do
    begin
      bus(1'b0, `EE_CTRL_OFFSET, 32'h0);
      n++;
    end
    while (rd[b] !== v && n < 4000);
    hang(n == 4000);
  endtask

  task automatic scl_rise(output int n);
    logic p;
    n = 0;
    do
    begin
      p = EE_SCL;
      @(posedge CLOCK);
      n++;
    end
    while (!(p === 1'b0 && EE_SCL === 1'b1) && n < 9000);
    hang(n == 9000);
  endtask

  task automatic t_reset();
    repeat (6) @(posedge CLOCK);
    chk("rst_pins", 32'h26,
        {HREADYOUT, HRESP, IRQ, EE_SCL, EE_SDA_OEN, EE_SDA_OUT});
    chk("rst_load", 32'h0, CFG_LOAD);
    RSTN <= 1'b1;
    @(posedge CLOCK);
    bus(1'b0, `EE_CTRL_OFFSET, 32'h0);
    chk("ctrl_rst", 32'h0000_0100, rd);
  endtask

  task automatic t_autoload();
    int n;
    bus(1'b1, `EE_CTRL_OFFSET, 32'h0000_00B0);
    bus(1'b0, `EE_CTRL_OFFSET, 32'h0);
    chk("al_busy", 32'h0000_01B0, rd);
    scl_rise(n);
    scl_rise(n);
    chk("al_scl_period", 32'd4, n);
    poll(8, 1'b0);
    chk("al_done", 32'h0000_00B8, rd);
    chk("al_count", 32'd2, load_q.size());
    foreach (load_q[i])
      chk("al_word", {7'(i), mword(i)}, load_q[i]);
    bus(1'b0, `EE_IRQ_STAT_OFFSET, 32'h0);
    chk("al_irq", 32'h4, rd);
    chk("irq_masked", 32'h0, IRQ);
    bus(1'b1, `EE_IRQ_MASK_OFFSET, 32'h4);
    @(posedge CLOCK);
    chk("irq_on", 32'h1, IRQ);
    bus(1'b1, `EE_IRQ_STAT_OFFSET, 32'h4);
    @(posedge CLOCK);
    chk("irq_off", 32'h0, IRQ);
    bus(1'b1, `EE_IRQ_MASK_OFFSET, 32'h2);
  endtask

  task automatic sw(input logic c, input logic [6:0] a, input logic [15:0] d,
                    input logic [15:0] e, input logic er);
    bus(1'b1, `EE_CTRL_OFFSET, {d, a, 7'h0C, c, 1'b1});
    poll(0, 1'b0);
    chk("sw_ctrl", {e, a, 6'h07, er, c, 1'b0}, rd);
    bus(1'b0, `EE_IRQ_STAT_OFFSET, 32'h0);
    chk("sw_irq", {30'h0, er, 1'b1}, rd);
    chk("sw_line", er, IRQ);
    bus(1'b1, `EE_IRQ_STAT_OFFSET, 32'h3);
  endtask

  task automatic t_soft();
    sw(1'b1, 7'h05, 16'hBEEF, 16'hBEEF, 1'b0);
    chk("ee_mem", 32'hBEEF,
        {eeprom_model_inst.mem[10], eeprom_model_inst.mem[11]});
    sw(1'b0, 7'h09, 16'h0000, mword(9), 1'b0);
    sw(1'b0, 7'h05, 16'h1234, 16'hBEEF, 1'b0);
    nack <= 1'b1;
    sw(1'b0, 7'h09, 16'h7777, 16'h7777, 1'b1);
    nack <= 1'b0;
    sw(1'b0, 7'h09, 16'h0000, mword(9), 1'b0);
  endtask

  task automatic t_divider();
    int n;
    int dv [4] = '{4096, 2048, 1024, 128};
    for (int k = 0; k < 4; k++)
    begin
      bus(1'b1, `EE_CTRL_OFFSET, {16'h0, 7'h07, 3'h0, 2'(k), 4'h3});
      scl_rise(n);
      scl_rise(n);
      chk("scl_period", dv[k], n);
      bus(1'b1, `EE_CTRL_OFFSET, {16'h0, 7'h07, 5'h03, 4'h3});
      poll(0, 1'b0);
    end
  endtask

  initial
  begin
    {RSTN, HSEL, HWRITE, nack, HADDR, HTRANS, HWDATA} = '0;
    HSIZE = 3'h2;
    bad_count = 0;
    num_checks = 0;
    t_reset();
    t_autoload();
    t_soft();
    t_divider();
    bus(1'b1, 8'h7C, 32'hFFFF_FFFF);
    bus(1'b0, 8'h7C, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("resp", 32'h0, HRESP);
    close_out();
  end
endmodule

// file: testbench/eeprom_model.sv
`timescale 1ns/1ps

module eeprom_model
(
  // Serial link.
  input  wire logic scl,
  input  wire logic sda,
  // Withhold every acknowledge while high.
  input  wire logic nack,
  // High while the model holds the data line low.
  output logic      pull_low
);
  logic [7:0] mem [0:255];
  logic [7:0] sh;
  logic [7:0] ptr;
  int         cnt;
  int         phase;

  initial
  begin
    pull_low = 1'b0;
    phase = 4;
    cnt = 0;
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h5A;
  end

  // A data edge while the clock is high frames a transfer.
  always @(negedge sda)
    if (scl === 1'b1)
    begin
      phase = 0;
      cnt = -1;
      pull_low = 1'b0;
    end

  always @(posedge sda)
    if (scl === 1'b1)
      phase = 4;

  // A master that does not acknowledge a read byte ends the read.
  always @(posedge scl)
    if (phase < 4)
    begin
      if (cnt < 8)
        sh = {sh[6:0], sda};
      else if (phase == 3 && sda === 1'b1)
        phase = 4;
    end

  always @(negedge scl)
    if (phase < 4)
    begin
      cnt = cnt + 1;
      if (cnt == 8)
      begin
        pull_low = phase != 3 && nack !== 1'b1;
        if (phase == 0)
          phase = sh[0] ? 3 : 1;
        else if (phase == 1)
        begin
          ptr = sh;
          phase = 2;
        end
        else if (phase == 2)
        begin
          mem[ptr] = sh;
          ptr = ptr + 8'h01;
        end
        else
          ptr = ptr + 8'h01;
        if (nack === 1'b1)
          phase = 4;
      end
      else
      begin
        if (cnt == 9)
          cnt = 0;
        pull_low = phase == 3 && mem[ptr][7 - cnt] === 1'b0;
      end
    end
endmodule
